// ===== rtl/decode_if.sv
`timescale 1ns/1ps
// Purpose: carries one classified opcode from the classifier to the decoder
// Assumes: single clock domain
// Notes:   combinational classification result
interface decode_if;
	import decode_pkg::*;
	logic [7:0]  opcode;
	logic [7:0]  ext_op;
	logic        small_model;
	op_kind_e    kind;
	format_e     fmt;
	logic        privileged;
	logic        known;
	modport decoder (output opcode, output ext_op, output small_model,
		input kind, input fmt, input privileged, input known);
	modport classifier (input opcode, input ext_op, input small_model,
		output kind, output fmt, output privileged, output known);
endinterface

// ===== rtl/decode_pkg.sv
// Purpose: shared constants and types for the opcode decoder
// Assumes: big-endian bit numbering, bit 0 is the msb of a 48-bit instruction
// Notes:   opcode values are the instruction-set encodings
package decode_pkg;
	localparam int INSTR_W       = 48;
	// field positions in big-endian numbering
	localparam int OPC_HI        = 0;
	localparam int OPC_LO        = 7;
	localparam int LEN_HI        = 8;
	localparam int LEN_LO        = 15;
	localparam int B1_HI         = 16;
	localparam int B1_LO         = 19;
	localparam int D1_HI         = 20;
	localparam int D1_LO         = 31;
	localparam int B2_HI         = 32;
	localparam int B2_LO         = 35;
	localparam int D2_HI         = 36;
	localparam int D2_LO         = 47;
	localparam int XOP_HI        = 8;
	localparam int XOP_LO        = 15;

	localparam logic [7:0] OP_SYS_MASK_SET   = 8'h80;
	localparam logic [7:0] OP_LOAD_STATUS    = 8'h82;
	localparam logic [7:0] OP_EXT_83         = 8'h83;
	localparam logic [7:0] OP_EXT_84         = 8'h84;
	localparam logic [7:0] OP_IDX_HIGH       = 8'h86;
	localparam logic [7:0] OP_IDX_LOW_EQ     = 8'h87;
	localparam logic [7:0] OP_SR_SINGLE_LOG  = 8'h88;
	localparam logic [7:0] OP_SR_DBL_LOG     = 8'h8C;
	localparam logic [7:0] OP_SL_DBL_LOG     = 8'h8D;
	localparam logic [7:0] OP_IO_START       = 8'h9C;
	localparam logic [7:0] OP_IO_HALT        = 8'h9E;
	localparam logic [7:0] OP_SUP_CALL       = 8'h0A;
	localparam logic [7:0] OP_CTL_STORE_LOAD = 8'hB1;
	localparam logic [7:0] OP_EXT_B2         = 8'hB2;
	localparam logic [7:0] OP_CMP_MASKED     = 8'hBD;
	localparam logic [7:0] OP_STORE_MASKED   = 8'hBE;
	localparam logic [7:0] OP_INSERT_MASKED  = 8'hBF;
	localparam logic [7:0] OP_CMP_IMM_SKIP   = 8'hE1;
	localparam logic [7:0] OP_TEST_MASK_SKIP = 8'hE2;
	localparam logic [7:0] OP_FL_LOAD_TEST   = 8'h22;
	localparam logic [7:0] OP_FS_LOAD_TEST   = 8'h32;
	localparam logic [7:0] XOP_STATUS_STORE  = 8'h02;

	localparam logic [3:0] LEN_RR   = 4'h2;
	localparam logic [3:0] LEN_MID  = 4'h4;
	localparam logic [3:0] LEN_SS   = 4'h6;

	typedef enum logic [2:0] {
		FMT_RR  = 3'h0,
		FMT_RX  = 3'h1,
		FMT_RS  = 3'h2,
		FMT_SI  = 3'h3,
		FMT_SS  = 3'h4,
		FMT_S   = 3'h5
	} format_e;

	typedef enum logic [4:0] {
		OPK_GENERAL          = 5'h00,
		OPK_IDX_HIGH         = 5'h01,
		OPK_IDX_LOW_EQ       = 5'h02,
		OPK_CMP_IMM_SKIP     = 5'h03,
		OPK_TEST_MASK_SKIP   = 5'h04,
		OPK_INSERT_MASKED    = 5'h05,
		OPK_STORE_MASKED     = 5'h06,
		OPK_SL_DBL_LOG       = 5'h07,
		OPK_SR_DBL_LOG       = 5'h08,
		OPK_SR_SINGLE_LOG    = 5'h09,
		OPK_CMP_MASKED       = 5'h0A,
		OPK_FL_LOAD_TEST     = 5'h0B,
		OPK_FS_LOAD_TEST     = 5'h0C,
		OPK_STATUS_STORE     = 5'h0D,
		OPK_CTL_STORE_LOAD   = 5'h0E,
		OPK_LOAD_STATUS      = 5'h0F,
		OPK_SYS_MASK_SET     = 5'h10,
		OPK_IO_START         = 5'h11,
		OPK_IO_HALT          = 5'h12,
		OPK_SUP_CALL         = 5'h13,
		OPK_FLOAT            = 5'h14,
		OPK_DECIMAL          = 5'h15,
		OPK_PRIV_OTHER       = 5'h16,
		OPK_INVALID          = 5'h1F
	} op_kind_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_TRAP  = 2'b10
	} dec_state_e;
endpackage

// ===== rtl/opcode_classify.sv
`timescale 1ns/1ps
// Purpose: maps an opcode onto operation kind, format and privilege class
// Assumes: opcode and extension byte are stable while classified
// Notes:   pure combinational table
module opcode_classify
	import decode_pkg::*;
(
	decode_if.classifier cls
);
	function automatic logic is_priv(input logic [7:0] op, input logic [7:0] xop, input logic sm);
		logic r;
		r = 1'b0;
		unique case (op)
			8'h80, 8'h82, 8'h99, 8'h9C, 8'h9E, 8'h9F, 8'h09, 8'h03, 8'h08,
			8'hB6, 8'hB7, 8'hB8, 8'hB0, 8'h84: r = 1'b1;
			8'h83: r = 1'b1;
			8'hB1: r = sm;
			8'hB2: r = (xop == 8'h04) || (xop == 8'h02);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	logic [7:0] op;
	logic [7:0] xop;
	assign op  = cls.opcode;
	assign xop = cls.ext_op;

	wire fam_rr  = (op[7:6] == 2'b00);
	wire fam_rx  = (op[7:6] == 2'b01);
	wire fam_ss  = (op[7:4] == 4'hD) || (op[7:4] == 4'hF) || (op == OP_CMP_IMM_SKIP)
		|| (op == OP_TEST_MASK_SKIP);
	wire fam_rs  = (op[7:4] == 4'h8 && op[3:2] != 2'b00 && op != 8'h84 && op != 8'h83)
		|| op == 8'h86 || op == 8'h87 || op == 8'h98 || op == 8'h9B
		|| (op[7:4] == 4'hB && op != OP_EXT_B2);
	// extension codes valid for opcode 83; codes 02, 14 and 1C are valid on the small model only
	wire ext83_ok = (xop == 8'h13) || (xop == 8'h0E) || (xop == 8'h16) || (xop == 8'h11)
		|| (xop == 8'h15) || (xop == 8'h0F) || (xop == 8'h1D)
		|| (cls.small_model && (xop == XOP_STATUS_STORE || xop == 8'h14 || xop == 8'h1C));
	wire gen_known = fam_rr ? !(op inside {8'h00, 8'h01, 8'h02, 8'h0B, 8'h0C, 8'h0D,
			8'h25, 8'h26, 8'h27, 8'h35, 8'h36, 8'h37})
		: fam_rx ? !(op inside {8'h51, 8'h52, 8'h53, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65,
			8'h66, 8'h67, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77})
		: (op inside {8'h80, 8'h82, 8'h84, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B,
			8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95,
			8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9E, 8'h9F, 8'hAF,
			8'hB0, 8'hB2, 8'hB6, 8'hB7, 8'hB8, 8'hBD, 8'hBE, 8'hBF, 8'hE1, 8'hE2})
			|| (op[7:4] == 4'hD && !(op inside {8'hD0, 8'hD8, 8'hD9, 8'hDA, 8'hDB}))
			|| (op inside {8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF8, 8'hF9, 8'hFA, 8'hFB,
			8'hFC, 8'hFD});

	always_comb begin
		cls.kind = OPK_GENERAL;
		unique case (op)
			OP_IDX_HIGH:       cls.kind = OPK_IDX_HIGH;
			OP_IDX_LOW_EQ:     cls.kind = OPK_IDX_LOW_EQ;
			OP_CMP_IMM_SKIP:   cls.kind = OPK_CMP_IMM_SKIP;
			OP_TEST_MASK_SKIP: cls.kind = OPK_TEST_MASK_SKIP;
			OP_INSERT_MASKED:  cls.kind = OPK_INSERT_MASKED;
			OP_STORE_MASKED:   cls.kind = OPK_STORE_MASKED;
			OP_SL_DBL_LOG:     cls.kind = OPK_SL_DBL_LOG;
			OP_SR_DBL_LOG:     cls.kind = OPK_SR_DBL_LOG;
			OP_SR_SINGLE_LOG:  cls.kind = OPK_SR_SINGLE_LOG;
			OP_CMP_MASKED:     cls.kind = OPK_CMP_MASKED;
			OP_FL_LOAD_TEST:   cls.kind = OPK_FL_LOAD_TEST;
			OP_FS_LOAD_TEST:   cls.kind = OPK_FS_LOAD_TEST;
			OP_EXT_83:         cls.kind = (cls.small_model && xop == XOP_STATUS_STORE)
				? OPK_STATUS_STORE : OPK_PRIV_OTHER;
			OP_CTL_STORE_LOAD: cls.kind = cls.small_model
				? OPK_CTL_STORE_LOAD : OPK_INVALID;
			OP_LOAD_STATUS:    cls.kind = OPK_LOAD_STATUS;
			OP_SYS_MASK_SET:   cls.kind = OPK_SYS_MASK_SET;
			OP_IO_START:       cls.kind = OPK_IO_START;
			OP_IO_HALT:        cls.kind = OPK_IO_HALT;
			OP_SUP_CALL:       cls.kind = OPK_SUP_CALL;
			default: begin
				if (!gen_known)
					cls.kind = OPK_INVALID;
				else if (op[7:4] inside {4'h2, 4'h3, 4'h6, 4'h7})
					cls.kind = OPK_FLOAT;
				else if (op inside {8'hF0, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hDE, 8'hDF})
					cls.kind = OPK_DECIMAL;
				else if (is_priv(op, xop, cls.small_model))
					cls.kind = OPK_PRIV_OTHER;
				else
					cls.kind = OPK_GENERAL;
			end
		endcase
		if (op == OP_EXT_83 && !ext83_ok)
			cls.kind = OPK_INVALID;
		if (op == OP_EXT_B2 && !(xop inside {8'h02, 8'h04, 8'h05}))
			cls.kind = OPK_INVALID;
		if (op == OP_EXT_84 && xop != 8'h17)
			cls.kind = OPK_INVALID;
	end

	always_comb begin
		if (fam_ss)
			cls.fmt = FMT_SS;
		else if (fam_rr)
			cls.fmt = FMT_RR;
		else if (fam_rx && op != OP_IDX_LOW_EQ)
			cls.fmt = FMT_RX;
		else if (fam_rs)
			cls.fmt = FMT_RS;
		else
			cls.fmt = FMT_SI;
	end

	assign cls.privileged = is_priv(op, xop, cls.small_model);
	assign cls.known      = (cls.kind != OPK_INVALID);
endmodule

// ===== rtl/opcode_decode_privilege_check.sv
`timescale 1ns/1ps
// Purpose: instruction decode and privilege check for the processing unit
// Assumes: instruction word arrives left-justified, bit 0 is the msb
// Notes:   one-cycle registered decode per accepted instruction
module opcode_decode_privilege_check
	import decode_pkg::*;
#(
	parameter bit SMALL_MODEL = 1'b0
)
(
	input  wire logic                CLK_I,
	input  wire logic                RST_I,
	input  wire logic [INSTR_W-1:0]  INSTR_I,
	input  wire logic                INSTR_VALID_I,
	input  wire logic                EXT_INTR_I,
	output logic                     SUPERVISOR_O,
	output logic                     ISSUE_O,
	output logic [4:0]               OP_KIND_O,
	output logic [2:0]               FORMAT_O,
	output logic [3:0]               INSTR_LEN_O,
	output logic [3:0]               BASE1_O,
	output logic                     BASE1_ZERO_O,
	output logic [11:0]              DISP1_O,
	output logic [3:0]               BASE2_O,
	output logic                     BASE2_ZERO_O,
	output logic [11:0]              DISP2_O,
	output logic [7:0]               SHARED_LEN_O,
	output logic                     SHARED_LEN_VALID_O,
	output logic                     PRIV_EXC_O,
	output logic                     INVALID_EXC_O,
	output logic                     INTR_REQ_O
);
	// big-endian bit n sits at vector index INSTR_W-1-n
	function automatic logic [11:0] field12(input logic [INSTR_W-1:0] w, input int hi);
		return w[INSTR_W-1-hi -: 12];
	endfunction
	function automatic logic [3:0] field4(input logic [INSTR_W-1:0] w, input int hi);
		return w[INSTR_W-1-hi -: 4];
	endfunction

	decode_if dif ();
	opcode_classify u_classify (
		.cls (dif.classifier)
	);

	assign dif.opcode      = INSTR_I[INSTR_W-1-OPC_HI -: 8];
	assign dif.ext_op      = INSTR_I[INSTR_W-1-XOP_HI -: 8];
	assign dif.small_model = SMALL_MODEL;

	dec_state_e  state_reg;
	dec_state_e  state_next;
	// current status word supervisor-state bit lives here, 1 = supervisor; SUPERVISOR_O is loaded with the same next value
	logic        supervisor_reg;
	logic        supervisor_next;

	wire priv_violation = dif.privileged && !supervisor_reg;
	wire invalid_op     = !dif.known;
	wire take           = INSTR_VALID_I && (state_reg == ST_IDLE || state_reg == ST_ISSUE);
	wire exec_ok        = take && !priv_violation && !invalid_op;
	wire exc_any        = take && (priv_violation || invalid_op);
	wire is_load_status = dif.kind == OPK_LOAD_STATUS;
	wire is_sup_call    = dif.kind == OPK_SUP_CALL;
	wire [3:0] len_w    = (dif.fmt == FMT_RR) ? LEN_RR
		: (dif.fmt == FMT_SS) ? LEN_SS : LEN_MID;
	wire is_dx          = dif.fmt == FMT_SS && dif.opcode[7:4] == 4'hD;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE, ST_ISSUE: begin
				if (exc_any)
					state_next = ST_TRAP;
				else if (exec_ok)
					state_next = ST_ISSUE;
				else
					state_next = ST_IDLE;
			end
			ST_TRAP: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_comb begin
		supervisor_next = supervisor_reg;
		if (exec_ok && is_load_status)
			supervisor_next = 1'b0;
		if ((exec_ok && is_sup_call) || exc_any || EXT_INTR_I)
			supervisor_next = 1'b1;
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_reg      <= ST_IDLE;
			supervisor_reg <= 1'b1;
		end else begin
			state_reg      <= state_next;
			supervisor_reg <= supervisor_next;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ISSUE_O            <= 1'b0;
			PRIV_EXC_O         <= 1'b0;
			INVALID_EXC_O      <= 1'b0;
			INTR_REQ_O         <= 1'b0;
			SUPERVISOR_O       <= 1'b1;
			OP_KIND_O          <= 5'h00;
			FORMAT_O           <= 3'h0;
			INSTR_LEN_O        <= 4'h0;
			BASE1_O            <= 4'h0;
			BASE1_ZERO_O       <= 1'b1;
			DISP1_O            <= 12'h000;
			BASE2_O            <= 4'h0;
			BASE2_ZERO_O       <= 1'b1;
			DISP2_O            <= 12'h000;
			SHARED_LEN_O       <= 8'h00;
			SHARED_LEN_VALID_O <= 1'b0;
		end else begin
			ISSUE_O       <= exec_ok;
			PRIV_EXC_O    <= take && priv_violation;
			INVALID_EXC_O <= take && invalid_op && !priv_violation;
			INTR_REQ_O    <= exc_any;
			SUPERVISOR_O  <= supervisor_next;
			if (take) begin
				OP_KIND_O          <= 5'(dif.kind);
				FORMAT_O           <= 3'(dif.fmt);
				INSTR_LEN_O        <= len_w;
				BASE1_O            <= field4(INSTR_I, B1_HI);
				BASE1_ZERO_O       <= field4(INSTR_I, B1_HI) == 4'h0;
				DISP1_O            <= field12(INSTR_I, D1_HI);
				BASE2_O            <= field4(INSTR_I, B2_HI);
				BASE2_ZERO_O       <= field4(INSTR_I, B2_HI) == 4'h0;
				DISP2_O            <= field12(INSTR_I, D2_HI);
				SHARED_LEN_O       <= INSTR_I[INSTR_W-1-LEN_HI -: 8];
				SHARED_LEN_VALID_O <= is_dx;
			end
		end
	end

	a_priv_trap: assert property (@(posedge CLK_I) disable iff (RST_I)
		take && dif.privileged && !supervisor_reg |=> PRIV_EXC_O && INTR_REQ_O && !ISSUE_O)
		else $error("privileged op in problem mode not trapped");
	a_priv_needs_sup: assert property (@(posedge CLK_I) disable iff (RST_I)
		ISSUE_O && $past(dif.privileged) |-> $past(supervisor_reg))
		else $error("privileged op issued outside supervisor mode");
	a_sup_all_ok: assert property (@(posedge CLK_I) disable iff (RST_I)
		take && supervisor_reg && dif.known |=> ISSUE_O)
		else $error("supervisor mode refused a known op");
	a_problem_ok: assert property (@(posedge CLK_I) disable iff (RST_I)
		take && !supervisor_reg && dif.known && !dif.privileged
		|=> ISSUE_O && (SUPERVISOR_O == ($past(is_sup_call) || $past(EXT_INTR_I))))
		else $error("nonprivileged op refused in problem mode");
	a_load_status: assert property (@(posedge CLK_I) disable iff (RST_I)
		exec_ok && is_load_status && !EXT_INTR_I |=> !supervisor_reg)
		else $error("load status word did not enter problem mode");
	a_call_sup: assert property (@(posedge CLK_I) disable iff (RST_I)
		EXT_INTR_I || (exec_ok && is_sup_call) |=> supervisor_reg)
		else $error("call or interrupt did not enter supervisor mode");
	a_mode_stable: assert property (@(posedge CLK_I) disable iff (RST_I)
		!take && !EXT_INTR_I |=> $stable(supervisor_reg))
		else $error("mode changed without cause");
	a_invalid_exc: assert property (@(posedge CLK_I) disable iff (RST_I)
		take && !dif.known |=> INTR_REQ_O && !ISSUE_O ##1 !ISSUE_O)
		else $error("unknown opcode not excepted");
	a_len_ss: assert property (@(posedge CLK_I) disable iff (RST_I)
		take && dif.fmt == FMT_SS |=> INSTR_LEN_O == 4'h6)
		else $error("two-memory-operand length wrong");
	a_base1_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
		take |=> BASE1_ZERO_O == (BASE1_O == 4'h0))
		else $error("first base zero flag wrong");
	a_base2_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
		take |=> BASE2_ZERO_O == (BASE2_O == 4'h0))
		else $error("second base zero flag wrong");
endmodule

// ===== testbench/main_store.sv
// Purpose: main storage model that hands instruction halfwords to the decoder
// Assumes: three consecutive halfwords form one left-justified 48-bit word
// Notes:   outside a fetch the word lines show the inverse of the last word
`timescale 1ns/1ps
module main_store (
	input  wire logic        clk_i,
	input  wire logic        fetch_i,
	input  wire logic [5:0]  addr_i,
	output logic      [47:0] word_o,
	output logic             valid_o
);
	logic [15:0] mem [0:63];
	logic [47:0] last_reg;
	logic [47:0] fetched;

	assign fetched = {mem[addr_i], mem[addr_i + 6'h01], mem[addr_i + 6'h02]};
	assign valid_o = fetch_i;
	// released lines must not keep the old value, or a stale word could pass
	assign word_o  = fetch_i ? fetched : ~last_reg;

	initial last_reg = 48'h0;
	always @(posedge clk_i) begin
		if (fetch_i) begin
			last_reg <= fetched;
		end
	end
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the decode and privilege check block
// Assumes: inputs change on the falling edge, outputs read on the next one
// Notes:   dut runs the default variant, dut_small the small model variant
`timescale 1ns/1ps
module tb_top
	import decode_pkg::*;
;
	logic        clk;
	logic        rst;
	logic        ext_intr;
	logic        fetch;
	logic [5:0]  addr;
	logic [5:0]  slot;
	logic [47:0] instr;
	logic        instr_valid;
	wire         sup, issue, b1z, b2z, slv, priv, inv, intr;
	wire         sm_issue, sm_inv;
	wire  [2:0]  fmt;
	wire  [4:0]  kind, sm_kind;
	wire  [3:0]  len, b1, b2;
	wire  [11:0] d1, d2;
	wire  [7:0]  slen;
	int          fails;
	int          n_compared;

	main_store store (.clk_i(clk), .fetch_i(fetch), .addr_i(addr), .word_o(instr), .valid_o(instr_valid));

	opcode_decode_privilege_check dut (
		.CLK_I(clk), .RST_I(rst), .INSTR_I(instr), .INSTR_VALID_I(instr_valid), .EXT_INTR_I(ext_intr),
		.SUPERVISOR_O(sup), .ISSUE_O(issue), .OP_KIND_O(kind), .FORMAT_O(fmt), .INSTR_LEN_O(len),
		.BASE1_O(b1), .BASE1_ZERO_O(b1z), .DISP1_O(d1), .BASE2_O(b2), .BASE2_ZERO_O(b2z), .DISP2_O(d2),
		.SHARED_LEN_O(slen), .SHARED_LEN_VALID_O(slv), .PRIV_EXC_O(priv), .INVALID_EXC_O(inv),
		.INTR_REQ_O(intr));

	opcode_decode_privilege_check #(.SMALL_MODEL(1'b1)) dut_small (
		.CLK_I(clk), .RST_I(rst), .INSTR_I(instr), .INSTR_VALID_I(instr_valid), .EXT_INTR_I(ext_intr),
		.SUPERVISOR_O(), .ISSUE_O(sm_issue), .OP_KIND_O(sm_kind), .FORMAT_O(), .INSTR_LEN_O(),
		.BASE1_O(), .BASE1_ZERO_O(), .DISP1_O(), .BASE2_O(), .BASE2_ZERO_O(), .DISP2_O(),
		.SHARED_LEN_O(), .SHARED_LEN_VALID_O(), .PRIV_EXC_O(), .INVALID_EXC_O(sm_inv),
		.INTR_REQ_O());

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// load the word into storage and offer it from this falling edge on
	task automatic put(input logic [47:0] w);
		@(negedge clk);
		store.mem[slot] = w[47:32];
		store.mem[slot + 6'h01] = w[31:16];
		store.mem[slot + 6'h02] = w[15:0];
		addr = slot;
		fetch = 1'b1;
		slot = (slot >= 6'd57) ? 6'd0 : slot + 6'd3;
	endtask

	task automatic send(input logic [47:0] w);
		put(w);
		@(negedge clk);
		fetch = 1'b0;
	endtask

	task automatic to_problem();
		send({OP_LOAD_STATUS, 40'h0});
		chk("load_status_word_op issue", issue, 1'b1);
		chk("load_status_word_op mode", sup, 1'b0);
	endtask

	task automatic t_reset();
		chk("reset mode", sup, 1'b1);
		chk("reset pulses", {issue, priv, inv, intr}, 4'h0);
		chk("reset zero flags", {b1z, b2z}, 2'b11);
	endtask

	task automatic t_fields();
		send({8'hD2, 8'h3C, 4'hA, 12'h123, 4'h5, 12'hABC});
		chk("b1", {b1z, b1}, 5'h0A);
		chk("d1", d1, 12'h123);
		chk("b2", {b2z, b2}, 5'h05);
		chk("d2", d2, 12'hABC);
		chk("shared len", {slv, slen}, 9'h13C);
		chk("ss len", len, 4'h6);
		send({8'hF2, 8'h5A, 4'h0, 12'hFFF, 4'h0, 12'h001});
		chk("zero bases", {b1z, b2z}, 2'b11);
		chk("fx no shared", slv, 1'b0);
		chk("fx d2", d2, 12'h001);
	endtask

	task automatic t_opmap();
		logic [7:0] ops [12] = '{8'h86, 8'h87, 8'hE1, 8'hE2, 8'hBF, 8'hBE, 8'h8D, 8'h8C, 8'h88, 8'hBD,
			8'h22, 8'h32};
		logic [4:0] kinds [12] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
			5'h0B, 5'h0C};
		logic [3:0] lens [12] = '{4'h4, 4'h4, 4'h6, 4'h6, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h2, 4'h2};
		format_e fmts [12] = '{FMT_RS, FMT_RS, FMT_SS, FMT_SS, FMT_RS, FMT_RS, FMT_RS, FMT_RS, FMT_RS,
			FMT_RS, FMT_RR, FMT_RR};
		for (int i = 0; i < 12; i++) begin
			send({ops[i], 40'h0});
			chk("op issue", {issue, priv, inv}, 3'b100);
			chk("op kind", kind, kinds[i]);
			chk("op len", len, lens[i]);
			chk("op fmt", fmt, fmts[i]);
		end
	endtask

	task automatic t_privilege();
		logic [7:0] pops [4] = '{8'h80, 8'h9C, 8'h9E, 8'h82};
		send({8'h80, 40'h0});
		chk("sup priv issue", {issue, priv}, 2'b10);
		for (int i = 0; i < 4; i++) begin
			to_problem();
			send({pops[i], 40'h0});
			chk("trap pulses", {issue, priv, inv, intr}, 4'b0101);
			chk("trap mode", sup, 1'b1);
		end
	endtask

	task automatic t_problem();
		to_problem();
		send({8'h1A, 40'h0});
		chk("problem issue", {issue, priv, sup}, 3'b100);
		repeat (3) @(negedge clk);
		chk("mode held", sup, 1'b0);
		send({OP_SUP_CALL, 40'h0});
		chk("svc", {issue, sup}, 2'b11);
		to_problem();
		ext_intr = 1'b1;
		@(negedge clk);
		ext_intr = 1'b0;
		chk("intr mode", sup, 1'b1);
	endtask

	task automatic t_invalid();
		send({8'hFF, 40'h0});
		chk("unknown", {issue, priv, inv, intr}, 4'b0011);
		send({8'hB1, 40'h0});
		chk("small only", {issue, inv}, 2'b01);
		chk("small lcs", {sm_issue, sm_inv, sm_kind}, {2'b10, OPK_CTL_STORE_LOAD});
		send({OP_EXT_83, XOP_STATUS_STORE, 32'h0});
		chk("sts default", {issue, inv}, 2'b01);
		chk("sts small", {sm_issue, sm_inv, sm_kind}, {2'b10, OPK_STATUS_STORE});
		to_problem();
		send({OP_EXT_B2, 8'h05, 32'h0});
		chk("b2 nonpriv", {issue, priv, inv}, 3'b100);
		send({OP_EXT_B2, 8'h04, 32'h0});
		chk("b2 priv", {issue, priv, inv, intr}, 4'b0101);
	endtask

	task automatic t_order();
		to_problem();
		put({8'h9C, 40'h0});
		put({8'h1A, 40'h0});
		chk("first trap", priv, 1'b1);
		@(negedge clk);
		fetch = 1'b0;
		chk("refused", {issue, priv, inv}, 3'b000);
		put({8'h1A, 40'h0});
		put({8'h1B, 40'h0});
		chk("b2b first", issue, 1'b1);
		@(negedge clk);
		fetch = 1'b0;
		chk("b2b second", issue, 1'b1);
	endtask

	initial begin
		#(25 * 4000);
		fails++;
		final_report();
	end

	initial begin
		fails = 0;
		n_compared = 0;
		rst = 1'b1;
		ext_intr = 1'b0;
		fetch = 1'b0;
		addr = 6'h00;
		slot = 6'h00;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_fields();
		t_opmap();
		t_privilege();
		t_problem();
		t_invalid();
		t_order();
		final_report();
	end
endmodule
